// *** rtl/pllcr_clk_sel.sv ***
// Output clock selector between reference and divided oscillator
module pllcr_clk_sel (
  // Clock sources
  input wire logic ref_clk,
  input wire logic vco_div_clk,
  // Control
  input wire logic bypass,
  // Output
  output logic pll_clk
);

  // Plain mux: switching glitches; the oscillator keeps running meanwhile
  assign pll_clk = bypass ? ref_clk : vco_div_clk;

endmodule : pllcr_clk_sel

// *** rtl/pllcr_lock_qual.sv ***
// Lock qualifier: hides core lock while powered down or resettling
module pllcr_lock_qual
  import pllcr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core side
  input wire logic core_lock,
  input wire logic power_down,
  input wire logic restart,
  // Qualified lock
  output logic lock_vis
);

  logic [SETTLE_W-1:0] settle_r;
  logic settled;

  assign settled = (settle_r == SETTLE_W'(LOCK_SETTLE_CYC));

  // A divider change restarts the wait so stale lock is never shown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_r <= '0;
    end else if (power_down || restart) begin
      settle_r <= '0;
    end else if (!settled) begin
      settle_r <= settle_r + SETTLE_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_vis <= 1'b0;
    end else begin
      lock_vis <= core_lock && !power_down && !restart && settled;
    end
  end

  AST_LOCK_NEEDS_POWER: assert property (@(posedge pclk) disable iff (!presetn)
    power_down |=> !lock_vis)
    else $error("lock shown while powered down");

endmodule : pllcr_lock_qual

// *** rtl/pllcr_pkg.sv ***
// Shared constants, carriers and helpers for the PLL control register block
package pllcr_pkg;

  // ----------------------------------------------------------------
  // Instances and address map
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PLL = 2;
  localparam logic [31:0] SYS_BASE = 32'h4002_8000;
  localparam logic [31:0] USB_BASE = 32'h4002_C000;
  localparam logic [3:0] OFF_CS = 4'h0;
  localparam logic [3:0] OFF_PWR = 4'h4;
  localparam logic [3:0] OFF_FBDIV = 4'h8;
  localparam logic [3:0] OFF_PRIM = 4'hC;
  localparam int unsigned OFF_LSB = 2;
  localparam int unsigned OFF_MSB = 3;
  localparam int unsigned BLK_LSB = 4;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int unsigned CS_LOCK_BIT = 31;
  localparam int unsigned CS_BYPASS_BIT = 8;
  localparam int unsigned REFDIV_LSB = 0;
  localparam int unsigned REFDIV_W = 6;
  localparam int unsigned PWR_OSC_PD_BIT = 5;
  localparam int unsigned PWR_POST_PD_BIT = 3;
  localparam int unsigned PWR_MOD_PD_BIT = 2;
  localparam int unsigned PWR_MAIN_PD_BIT = 0;
  localparam int unsigned FBDIV_LSB = 0;
  localparam int unsigned FBDIV_W = 12;
  localparam int unsigned PD1_LSB = 16;
  localparam int unsigned PD2_LSB = 12;
  localparam int unsigned PD_W = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REFDIV_W-1:0] REFDIV_RST = 6'h01;
  localparam logic [FBDIV_W-1:0] FBDIV_RST = 12'h000;
  localparam logic [PD_W-1:0] POSTDIV_RST = 3'h7;
  localparam logic PWRDN_RST = 1'b1;
  localparam logic BYPASS_RST = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned LOCK_SETTLE_NS = 2000;
  localparam int unsigned LOCK_SETTLE_CYC = (LOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bypass;
    logic [REFDIV_W-1:0] refdiv;
    logic oscillator_power_down;
    logic output_divider_power_down;
    logic modulator_power_down;
    logic main_power_down;
    logic [FBDIV_W-1:0] fbdiv;
    logic [PD_W-1:0] first_output_divider;
    logic [PD_W-1:0] second_output_divider;
  } pllcr_ctl_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pllcr_apb_req_type;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } pllcr_apb_rsp_type;

  localparam pllcr_ctl_type CTL_RST = '{
    bypass: BYPASS_RST, refdiv: REFDIV_RST,
    oscillator_power_down: PWRDN_RST, output_divider_power_down: PWRDN_RST,
    modulator_power_down: PWRDN_RST, main_power_down: PWRDN_RST,
    fbdiv: FBDIV_RST, first_output_divider: POSTDIV_RST,
    second_output_divider: POSTDIV_RST};

  // ----------------------------------------------------------------
  // Register image of one instance; reserved bits read as zero
  // ----------------------------------------------------------------
  function automatic logic [31:0] pllcr_word(pllcr_ctl_type c, logic lock, logic [3:0] off);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (off)
      OFF_CS: begin
        w[CS_LOCK_BIT] = lock;
        w[CS_BYPASS_BIT] = c.bypass;
        w[REFDIV_LSB +: REFDIV_W] = c.refdiv;
      end
      OFF_PWR: begin
        w[PWR_OSC_PD_BIT] = c.oscillator_power_down;
        w[PWR_POST_PD_BIT] = c.output_divider_power_down;
        w[PWR_MOD_PD_BIT] = c.modulator_power_down;
        w[PWR_MAIN_PD_BIT] = c.main_power_down;
      end
      OFF_FBDIV: w[FBDIV_LSB +: FBDIV_W] = c.fbdiv;
      default: begin
        w[PD1_LSB +: PD_W] = c.first_output_divider;
        w[PD2_LSB +: PD_W] = c.second_output_divider;
      end
    endcase
    return w;
  endfunction : pllcr_word

endpackage : pllcr_pkg

// *** rtl/pllcr_top.sv ***
// PLL control and status registers for two PLL instances on APB
module pllcr_top
  import pllcr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire pllcr_apb_req_type apb_req,
  output pllcr_apb_rsp_type apb_rsp,
  // Analogue core controls, one per PLL
  output pllcr_ctl_type core_ctl [NUM_PLL],
  input wire logic [NUM_PLL-1:0] core_lock,
  // Clock path
  input wire logic [NUM_PLL-1:0] ref_clk,
  input wire logic [NUM_PLL-1:0] vco_div_clk,
  output logic [NUM_PLL-1:0] pll_clk
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit;
  logic inst;
  logic [3:0] off;
  logic setup_ph;
  logic access_ph;
  logic wr_en;

  always_comb begin
    off = {apb_req.paddr[OFF_MSB:OFF_LSB], 2'b00};
    hit = 1'b0;
    inst = 1'b0;
    if (apb_req.paddr[31:BLK_LSB] == SYS_BASE[31:BLK_LSB]) begin
      hit = 1'b1;
    end else if (apb_req.paddr[31:BLK_LSB] == USB_BASE[31:BLK_LSB]) begin
      hit = 1'b1;
      inst = 1'b1;
    end
  end

  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign wr_en = access_ph && apb_req.pwrite && hit;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  pllcr_ctl_type ctl_r [NUM_PLL];
  pllcr_ctl_type ctl_nxt;
  logic [31:0] old_word;
  logic [31:0] new_word;
  logic [NUM_PLL-1:0] lock_vis;
  logic [NUM_PLL-1:0] restart;

  // Byte lanes not strobed keep their old contents
  always_comb begin
    old_word = pllcr_word(ctl_r[inst], lock_vis[inst], off);
    for (int b = 0; b < 4; b++) begin
      new_word[8*b +: 8] = apb_req.pstrb[b] ? apb_req.pwdata[8*b +: 8] : old_word[8*b +: 8];
    end
    ctl_nxt = ctl_r[inst];
    unique case (off)
      OFF_CS: begin
        ctl_nxt.bypass = new_word[CS_BYPASS_BIT];
        ctl_nxt.refdiv = new_word[REFDIV_LSB +: REFDIV_W];
      end
      OFF_PWR: begin
        ctl_nxt.oscillator_power_down = new_word[PWR_OSC_PD_BIT];
        ctl_nxt.output_divider_power_down = new_word[PWR_POST_PD_BIT];
        ctl_nxt.modulator_power_down = new_word[PWR_MOD_PD_BIT];
        ctl_nxt.main_power_down = new_word[PWR_MAIN_PD_BIT];
      end
      OFF_FBDIV: ctl_nxt.fbdiv = new_word[FBDIV_LSB +: FBDIV_W];
      default: begin
        ctl_nxt.first_output_divider = new_word[PD1_LSB +: PD_W];
        ctl_nxt.second_output_divider = new_word[PD2_LSB +: PD_W];
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PLL; i++) begin
        ctl_r[i] <= CTL_RST;
      end
    end else if (wr_en) begin
      ctl_r[inst] <= ctl_nxt;
    end
  end

  // Only a real change of either divider forces relock
  always_comb begin
    restart = '0;
    if (wr_en) begin
      restart[inst] = (ctl_nxt.refdiv != ctl_r[inst].refdiv) || (ctl_nxt.fbdiv != ctl_r[inst].fbdiv);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] prdata_r;

  // Read data is captured in the setup cycle so it is a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_r <= (hit && !apb_req.pwrite) ? old_word : 32'h0000_0000;
    end
  end

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.prdata = prdata_r;
  assign apb_rsp.pslverr = access_ph && !hit;

  // ----------------------------------------------------------------
  // Per-PLL lock and clock path
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_PLL; g++) begin : g_pll
    logic pwr_dn;

    assign pwr_dn = ctl_r[g].main_power_down || ctl_r[g].oscillator_power_down;
    assign core_ctl[g] = ctl_r[g];

    pllcr_lock_qual u_lock (
      .pclk(pclk),
      .presetn(presetn),
      .core_lock(core_lock[g]),
      .power_down(pwr_dn),
      .restart(restart[g]),
      .lock_vis(lock_vis[g])
    );

    // One primary output only; no secondary tap exists
    pllcr_clk_sel u_sel (
      .ref_clk(ref_clk[g]),
      .vco_div_clk(vco_div_clk[g]),
      .bypass(ctl_r[g].bypass),
      .pll_clk(pll_clk[g])
    );

    AST_BYPASS_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
      ctl_r[g].bypass |-> (pll_clk[g] == ref_clk[g]))
      else $error("bypass does not route reference clock");

    AST_BYPASS_KEEPS_OSC: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(ctl_r[g].bypass) |-> $stable(ctl_r[g].oscillator_power_down))
      else $error("bypass change touched oscillator power");

    AST_SETTLE_HIDES_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
      restart[g] |=> !lock_vis[g] [*8])
      else $error("lock shown too soon after divider change");

    AST_RESET_IMAGE: assert property (@(posedge pclk)
      $rose(presetn) |-> (ctl_r[g] == CTL_RST) && !lock_vis[g])
      else $error("reset values wrong");
  end

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    access_ph && !hit |-> apb_rsp.pslverr && (apb_rsp.prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  AST_FBDIV_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && (off == OFF_FBDIV) && (apb_req.pstrb == 4'hF)
      |=> ctl_r[$past(inst)].fbdiv == $past(apb_req.pwdata[FBDIV_W-1:0]))
    else $error("feedback divisor not stored");

  AST_POSTDIV_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && (off == OFF_PRIM) && (apb_req.pstrb == 4'hF)
      |=> ctl_r[$past(inst)].first_output_divider == $past(apb_req.pwdata[PD1_LSB +: PD_W]))
    else $error("post divider not stored");

  AST_OTHER_INST_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en |=> ($past(inst) ? $stable(ctl_r[0]) : $stable(ctl_r[1])))
    else $error("write leaked into other instance");

  AST_LOCK_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && hit && !apb_req.pwrite && (off == OFF_CS)
      |=> apb_rsp.prdata[CS_LOCK_BIT] == $past(lock_vis[inst]))
    else $error("lock bit readback wrong");

  AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && hit && (off == OFF_PWR) |=> apb_rsp.prdata[31:6] == 26'h0)
    else $error("reserved bits not zero");

  AST_REFDIV_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && (off == OFF_CS) && apb_req.pstrb[0]
      |=> ctl_r[$past(inst)].refdiv == $past(apb_req.pwdata[REFDIV_W-1:0]))
    else $error("reference divider not stored");

endmodule : pllcr_top

// *** sim/pllcr_top_tb_top.sv ***
// Self-checking testbench for the PLL control register block
module pllcr_top_tb_top;
  import pllcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn;
  pllcr_apb_req_type req;
  pllcr_apb_rsp_type rsp;
  pllcr_ctl_type ctl [NUM_PLL];
  logic [NUM_PLL-1:0] core_lock;
  logic [NUM_PLL-1:0] ref_clk;
  logic [NUM_PLL-1:0] vco_div_clk;
  logic [NUM_PLL-1:0] pll_clk;
  logic [31:0] seed = 32'd2003;
  logic [31:0] mdl [2][4];
  int err_count = 0;
  int checks = 0;

  always #50 pclk = ~pclk;

  pllcr_top dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .core_ctl(ctl),
    .core_lock(core_lock), .ref_clk(ref_clk), .vco_div_clk(vco_div_clk), .pll_clk(pll_clk));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] base(int i);
    return (i == 1) ? USB_BASE : SYS_BASE;
  endfunction : base

  // Writable bits per register; the lock flag is left out on purpose
  function automatic logic [31:0] wmask(int k);
    case (k)
      0: return 32'h0000_013F;
      1: return 32'h0000_002D;
      2: return 32'h0000_0FFF;
      default: return 32'h0007_7000;
    endcase
  endfunction : wmask

  function automatic logic [28:0] exp_ctl(int i);
    return {mdl[i][0][8], mdl[i][0][5:0], mdl[i][1][5], mdl[i][1][3], mdl[i][1][2], mdl[i][1][0],
      mdl[i][2][11:0], mdl[i][3][18:16], mdl[i][3][14:12]};
  endfunction : exp_ctl

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // APB master and register tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= s;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(int i, int k, logic [31:0] d, logic [3:0] s);
    logic [31:0] r;
    logic e;
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & wmask(k);
    apb(1'b1, base(i) + 32'(k * 4) + (xs() & 32'h3), d, s, r, e);
    mdl[i][k] = (mdl[i][k] & ~bm) | (d & bm);
    chk({e, r}, 33'h0);
  endtask : wr

  task automatic rd(int i, int k, logic lk);
    logic [31:0] r;
    logic e;
    apb(1'b0, base(i) + 32'(k * 4) + (xs() & 32'h3), 32'h0, 4'h0, r, e);
    chk({e, r}, {1'b0, mdl[i][k] | ((k == 0) ? {lk, 31'h0} : 32'h0)});
  endtask : rd

  // Output path follows the bypass bit of each instance
  always @(negedge pclk) begin
    if (presetn) begin
      for (int j = 0; j < 2; j++) begin
        chk({32'h0, pll_clk[j]}, {32'h0, mdl[j][0][8] ? ref_clk[j] : vco_div_clk[j]});
      end
    end
  end

  always @(posedge pclk) begin : clk_src
    logic [31:0] t;
    t = xs();
    ref_clk <= t[1:0];
    vco_div_clk <= t[3:2];
  end

  initial begin
    #2000000;
    err_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [31:0] rv;
    logic e;
    presetn = 1'b0;
    req = '0;
    core_lock = 2'b00;
    ref_clk = 2'b00;
    vco_div_clk = 2'b00;
    for (int i = 0; i < 2; i++) begin
      mdl[i][0] = 32'h0000_0001;
      mdl[i][1] = 32'h0000_002D;
      mdl[i][2] = 32'h0000_0000;
      mdl[i][3] = 32'h0007_7000;
    end
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      chk({4'h0, ctl[i]}, {4'h0, exp_ctl(i)});
      for (int k = 0; k < 4; k++) rd(i, k, 1'b0);
    end
    // Random traffic, partial strobes and unmapped addresses, lock held low
    for (int n = 0; n < 120; n++) begin
      r = xs();
      if (r[7:5] == 3'h0) begin
        apb(r[4], base(int'(r[0])) + 32'h10 + (r & 32'hFF0), xs(), 4'hF, rv, e);
        chk({e, rv}, {1'b1, 32'h0});
      end else if (r[4]) begin
        wr(int'(r[0]), int'(r[3:2]), xs(), r[8] ? 4'hF : r[12:9]);
      end else begin
        rd(int'(r[0]), int'(r[3:2]), 1'b0);
      end
      #1;
      for (int j = 0; j < 2; j++) chk({4'h0, ctl[j]}, {4'h0, exp_ctl(j)});
    end
    // Lock qualification per instance
    core_lock <= 2'b11;
    for (int i = 0; i < 2; i++) begin
      // Power down first so random leftovers cannot show an early lock
      wr(i, 1, 32'h0000_002D, 4'hF);
      wr(i, 2, 32'd100, 4'hF);
      wr(i, 0, 32'h0000_0001, 4'hF);
      wr(i, 1, 32'h0000_000C, 4'hF);
      repeat (14) @(posedge pclk);
      rd(i, 0, 1'b0);
      repeat (10) @(posedge pclk);
      rd(i, 0, 1'b1);
      wr(i, 2, 32'd120, 4'hF);
      rd(i, 0, 1'b0);
      repeat (25) @(posedge pclk);
      rd(i, 0, 1'b1);
      wr(i, 0, 32'h0000_0102, 4'hF);
      rd(i, 0, 1'b0);
      repeat (25) @(posedge pclk);
      wr(i, 2, 32'd120, 4'hF);
      rd(i, 0, 1'b1);
      core_lock[i] <= 1'b0;
      repeat (2) @(posedge pclk);
      rd(i, 0, 1'b0);
      core_lock[i] <= 1'b1;
      wr(i, 1, 32'h0000_000D, 4'hF);
      rd(i, 0, 1'b0);
      wr(i, 1, 32'h0000_000C, 4'hF);
      repeat (25) @(posedge pclk);
      rd(i, 0, 1'b1);
      wr(i, 1, 32'h0000_002C, 4'hF);
      rd(i, 0, 1'b0);
      #1;
      chk({4'h0, ctl[i]}, {4'h0, exp_ctl(i)});
    end
    end_of_test();
  end

endmodule : pllcr_top_tb_top
